// ### inc/flash_host_defines.vh
`ifndef FLASH_HOST_DEFINES_VH
`define FLASH_HOST_DEFINES_VH
// ==========================================
// timing
`define CLK_MHZ 20
`define T_WP_NS 35
`define T_WP_CYC ((`T_WP_NS * `CLK_MHZ + 999) / 1000)
`define T_ACC_NS 90
`define T_ACC_CYC ((`T_ACC_NS * `CLK_MHZ + 999) / 1000)
// ==========================================
// register offsets
`define REG_CTRL 8'h00
`define REG_ADDR 8'h04
`define REG_WDATA 8'h08
`define REG_RDATA 8'h0C
`define REG_STATUS 8'h10
`define REG_CFG 8'h14
// ==========================================
// fields
`define CTRL_OP_HI 3
`define CTRL_OP_LO 0
`define CTRL_SEL_HI 5
`define CTRL_SEL_LO 4
`define CTRL_POLL 6
`define CFG_BYTE 0
`define CFG_FRST 1
`define CFG_BYTE_RST 1'h0
`define CFG_FRST_RST 1'h1
`define ST_BUSY 0
`define ST_FAIL 1
`define ST_ILLEGAL 2
`define ST_READY 3
// ==========================================
// operations
`define OP_READ 4'h0
`define OP_RESET 4'h1
`define OP_AUTOSEL 4'h2
`define OP_SEC_ENTER 4'h3
`define OP_SEC_EXIT 4'h4
`define OP_PROGRAM 4'h5
`define OP_BYP_ENTER 4'h6
`define OP_BYP_PROG 4'h7
`define OP_BYP_RESET 4'h8
`define OP_CHIP_ERASE 4'h9
`define OP_SECT_ERASE 4'hA
`define OP_SECT_ADD 4'hB
`define OP_SUSPEND 4'hC
`define OP_RESUME 4'hD
`define OP_CFI 4'hE
`define OP_BAD 4'hF
// ==========================================
// command bytes and addresses
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_RESET 8'hF0
`define CMD_AUTOSEL 8'h90
`define CMD_SEC_ENTER 8'h88
`define CMD_EXIT 8'h00
`define CMD_PROGRAM 8'hA0
`define CMD_BYPASS 8'h20
`define CMD_ERASE_SETUP 8'h80
`define CMD_CHIP_ERASE 8'h10
`define CMD_SECT_ERASE 8'h30
`define CMD_SUSPEND 8'hB0
`define CMD_CFI 8'h98
`define ADR_U1_W 12'h0555
`define ADR_U1_B 12'h0AAA
`define ADR_U2_W 12'h02AA
`define ADR_U2_B 12'h0555
`define ADR_CFI_W 12'h0055
`define ADR_CFI_B 12'h00AA
`define ID_MAKER 12'h0000
`define ID_DEV_W 12'h0001
`define ID_DEV_B 12'h0002
`define ID_LOCK_W 12'h0003
`define ID_LOCK_B 12'h0006
`define ID_PROT_W 12'h0002
`define ID_PROT_B 12'h0004
`define BIT_TOGGLE 6
`define BIT_TIMEOUT 5
`endif

// ### rtl/flash_cycle.v
`include "flash_host_defines.vh"
// ==========================================
// one read or write cycle on the flash pins
module flash_cycle (
	input wire clk_sys, // system clock
	input wire rst_b, // async reset, low
	input wire start, // begin a cycle, pulse
	input wire isRead, // 1 read, 0 write
	input wire [20:0] cycAddr, // cycle address
	input wire [15:0] cycData, // write data
	input wire [15:0] dqSync, // synchronised data pins
	output reg [20:0] flashAddr, // address pins
	output reg [15:0] dqOut, // data pins out
	output reg dqOe, // data pins driven
	output reg ceN, // chip select, low
	output reg weN, // write strobe, low
	output reg oeN, // output enable, low
	output reg [15:0] readData, // captured read data
	output reg cycDone // cycle finished, pulse
);
	localparam P_IDLE = 4'b0001;
	localparam P_SETUP = 4'b0010;
	localparam P_PULSE = 4'b0100;
	localparam P_HOLD = 4'b1000;
	// read strobe covers access time plus the two synchroniser stages
	localparam integer RD_LEN_I = `T_ACC_CYC + 1;
	localparam integer WR_LEN_I = `T_WP_CYC - 1;
	localparam [2:0] RD_LEN = RD_LEN_I[2:0];
	localparam [2:0] WR_LEN = WR_LEN_I[2:0];

	reg [3:0] phase_r;
	reg [2:0] cnt_r;
	reg readCyc_r;

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			phase_r <= P_IDLE;
			cnt_r <= 3'h0;
			readCyc_r <= 1'b0;
			flashAddr <= 21'h00_0000;
			dqOut <= 16'h0000;
			dqOe <= 1'b0;
			ceN <= 1'b1;
			weN <= 1'b1;
			oeN <= 1'b1;
			readData <= 16'h0000;
			cycDone <= 1'b0;
		end else begin
			cycDone <= 1'b0;
			case (phase_r)
				P_IDLE: begin
					if (start) begin
						flashAddr <= cycAddr;
						dqOut <= cycData;
						dqOe <= ~isRead;
						readCyc_r <= isRead;
						phase_r <= P_SETUP;
					end
				end
				P_SETUP: begin
					// strobes fall together: address taken here
					ceN <= 1'b0;
					weN <= readCyc_r;
					oeN <= ~readCyc_r;
					cnt_r <= readCyc_r ? RD_LEN : WR_LEN;
					phase_r <= P_PULSE;
				end
				P_PULSE: begin
					if (cnt_r == 3'h0) begin
						// strobes rise together, data held past it
						ceN <= 1'b1;
						weN <= 1'b1;
						oeN <= 1'b1;
						if (readCyc_r)
							readData <= dqSync;
						phase_r <= P_HOLD;
					end else begin
						cnt_r <= cnt_r - 3'h1;
					end
				end
				P_HOLD: begin
					dqOe <= 1'b0;
					cycDone <= 1'b1;
					phase_r <= P_IDLE;
				end
				default: phase_r <= P_IDLE;
			endcase
		end
	end
endmodule // flash_cycle

// ### rtl/flash_host_ctrl.v
`include "flash_host_defines.vh"
// ==========================================
// flash command sequencer behind an AHB-Lite register file
module flash_host_ctrl (
	input wire clk_sys, // system clock, 20 MHz
	input wire rst_b, // async reset, low
	input wire hsel, // AHB slave select
	input wire [31:0] haddr, // AHB address
	input wire [1:0] htrans, // AHB transfer type
	input wire hwrite, // AHB write
	input wire [2:0] hsize, // AHB size, word only
	input wire hready, // AHB bus ready
	input wire [31:0] hwdata, // AHB write data
	output reg [31:0] hrdata, // AHB read data
	output reg hreadyout, // AHB slave ready
	output reg hresp, // AHB response, always OKAY
	output wire [20:0] flashAddr, // flash address pins
	input wire [15:0] dqIn, // flash data pins in
	output wire [15:0] dqOut, // flash data pins out
	output wire dqOe, // flash data pins driven
	output wire ceN, // flash chip select
	output wire weN, // flash write strobe
	output wire oeN, // flash output enable
	output reg flashRstN, // flash hardware reset
	input wire readyBusyN // flash ready/busy, open drain
);
	// ==========================================
	// states
	localparam S_IDLE = 4'b0001;
	localparam S_SEQ = 4'b0010;
	localparam S_POLL = 4'b0100;
	localparam S_ABORT = 4'b1000;

	reg [3:0] state_r;
	reg [3:0] opR;
	reg [1:0] selR;
	reg pollR;
	reg [20:0] addrR;
	reg [15:0] wdataR;
	reg byteMode;
	reg [2:0] stepR;
	reg cycStart_r;
	reg [15:0] rdataR;
	reg [15:0] prevR;
	reg pollPhase_r;
	reg tmoSeen_r;
	reg failR;
	reg illegalR;
	reg wrPend_r;
	reg [7:0] wrAddr_r;

	wire [15:0] dqSync;
	wire rbSync;
	wire [15:0] cycRdata;
	wire cycDone;

	// ==========================================
	// pin synchronisers
	sync_two_ff #(.W(16)) dqSyncU (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.asyncIn(dqIn),
		.syncOut(dqSync)
	);

	sync_two_ff #(.W(1)) rbSyncU (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.asyncIn(readyBusyN),
		.syncOut(rbSync)
	);

	// ==========================================
	// step table: address, data and kind of each bus cycle
	reg [11:0] u1;
	reg [11:0] u2;
	reg [11:0] idOff;
	reg [8:0] bank;
	reg [20:0] stepAddr;
	reg [15:0] stepData;
	reg stepRead;
	reg stepLast;
	reg [7:0] thirdCmd;
	reg erase;

	always @* begin
		u1 = byteMode ? `ADR_U1_B : `ADR_U1_W;
		u2 = byteMode ? `ADR_U2_B : `ADR_U2_W;
		bank = addrR[20:12];
		case (selR)
			2'h0: idOff = `ID_MAKER;
			2'h1: idOff = byteMode ? `ID_DEV_B : `ID_DEV_W;
			2'h2: idOff = byteMode ? `ID_LOCK_B : `ID_LOCK_W;
			default: idOff = byteMode ? `ID_PROT_B : `ID_PROT_W;
		endcase
		erase = (opR == `OP_CHIP_ERASE) || (opR == `OP_SECT_ERASE);
		case (opR)
			`OP_AUTOSEL: thirdCmd = `CMD_AUTOSEL;
			`OP_SEC_ENTER: thirdCmd = `CMD_SEC_ENTER;
			`OP_SEC_EXIT: thirdCmd = `CMD_AUTOSEL;
			`OP_PROGRAM: thirdCmd = `CMD_PROGRAM;
			`OP_BYP_ENTER: thirdCmd = `CMD_BYPASS;
			default: thirdCmd = `CMD_ERASE_SETUP;
		endcase
		// upper bits carry the bank; the device ignores them elsewhere
		stepAddr = {bank, u1};
		stepData = 16'h0000;
		stepRead = 1'b0;
		stepLast = 1'b0;
		case (opR)
			`OP_READ: begin
				stepAddr = addrR;
				stepRead = 1'b1;
				stepLast = 1'b1;
			end
			`OP_RESET: begin
				stepData = {8'h00, `CMD_RESET};
				stepLast = 1'b1;
			end
			`OP_BYP_PROG: begin
				if (stepR == 3'h0) begin
					stepData = {8'h00, `CMD_PROGRAM};
				end else begin
					stepAddr = addrR;
					stepData = wdataR;
					stepLast = 1'b1;
				end
			end
			`OP_BYP_RESET: begin
				if (stepR == 3'h0) begin
					stepData = {8'h00, `CMD_AUTOSEL};
				end else begin
					stepData = {8'h00, `CMD_EXIT};
					stepLast = 1'b1;
				end
			end
			`OP_SECT_ADD, `OP_RESUME: begin
				stepAddr = addrR;
				stepData = {8'h00, `CMD_SECT_ERASE};
				stepLast = 1'b1;
			end
			`OP_SUSPEND: begin
				stepAddr = addrR;
				stepData = {8'h00, `CMD_SUSPEND};
				stepLast = 1'b1;
			end
			`OP_CFI: begin
				stepAddr = {bank, byteMode ? `ADR_CFI_B : `ADR_CFI_W};
				stepData = {8'h00, `CMD_CFI};
				stepLast = 1'b1;
			end
			default: begin
				case (stepR)
					3'h0, 3'h3: begin
						stepData = {8'h00, `CMD_UNLOCK1};
						if (stepR == 3'h3 && !erase) begin
							stepLast = 1'b1;
							if (opR == `OP_AUTOSEL) begin
								stepAddr = {bank, idOff};
								stepRead = 1'b1;
							end else if (opR == `OP_PROGRAM) begin
								stepAddr = addrR;
								stepData = wdataR;
							end else begin
								stepData = {8'h00, `CMD_EXIT};
							end
						end
					end
					3'h1, 3'h4: begin
						stepAddr = {bank, u2};
						stepData = {8'h00, `CMD_UNLOCK2};
					end
					3'h2: begin
						stepData = {8'h00, thirdCmd};
						stepLast = (opR == `OP_SEC_ENTER) || (opR == `OP_BYP_ENTER);
					end
					default: begin
						stepLast = 1'b1;
						if (opR == `OP_SECT_ERASE) begin
							stepAddr = addrR;
							stepData = {8'h00, `CMD_SECT_ERASE};
						end else begin
							stepData = {8'h00, `CMD_CHIP_ERASE};
						end
					end
				endcase
			end
		endcase
	end

	// ==========================================
	// cycle engine
	wire inSeq = (state_r == S_SEQ);
	wire inAbort = (state_r == S_ABORT);
	wire [20:0] cycAddr = inSeq ? stepAddr : addrR;
	wire [15:0] cycData = inAbort ? {8'h00, `CMD_RESET} : stepData;
	wire cycRead = inSeq ? stepRead : (state_r == S_POLL);

	flash_cycle cycU (
		.clk_sys(clk_sys),
		.rst_b(rst_b),
		.start(cycStart_r),
		.isRead(cycRead),
		.cycAddr(cycAddr),
		.cycData(cycData),
		.dqSync(dqSync),
		.flashAddr(flashAddr),
		.dqOut(dqOut),
		.dqOe(dqOe),
		.ceN(ceN),
		.weN(weN),
		.oeN(oeN),
		.readData(cycRdata),
		.cycDone(cycDone)
	);

	// ==========================================
	// AHB-Lite slave, zero wait states
	wire apValid = hsel & hready & htrans[1];
	wire wrNow = wrPend_r & hready;
	wire startNow = wrNow && (wrAddr_r == `REG_CTRL) && (state_r == S_IDLE);
	wire [3:0] newOp = hwdata[`CTRL_OP_HI:`CTRL_OP_LO];
	reg [31:0] rdMux;

	always @* begin
		rdMux = 32'h0000_0000;
		case (haddr[7:0])
			`REG_CTRL: rdMux = {25'h000_0000, pollR, selR, opR};
			`REG_ADDR: rdMux = {11'h000, addrR};
			`REG_WDATA: rdMux = {16'h0000, wdataR};
			`REG_RDATA: rdMux = {16'h0000, rdataR};
			`REG_STATUS: rdMux = {28'h000_0000, rbSync, illegalR, failR, (state_r != S_IDLE)};
			`REG_CFG: rdMux = {30'h0000_0000, flashRstN, byteMode};
			default: rdMux = 32'h0000_0000;
		endcase
	end

	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
			addrR <= 21'h00_0000;
			wdataR <= 16'h0000;
			byteMode <= `CFG_BYTE_RST;
			flashRstN <= `CFG_FRST_RST;
		end else begin
			if (hready)
				wrPend_r <= apValid & hwrite;
			if (apValid) begin
				wrAddr_r <= haddr[7:0];
				if (!hwrite)
					hrdata <= rdMux;
			end
			if (wrNow) begin
				case (wrAddr_r)
					`REG_ADDR: addrR <= hwdata[20:0];
					`REG_WDATA: wdataR <= hwdata[15:0];
					`REG_CFG: begin
						byteMode <= hwdata[`CFG_BYTE];
						flashRstN <= hwdata[`CFG_FRST];
					end
					default: ;
				endcase
			end
		end
	end

	// ==========================================
	// sequencer; a command write while busy is dropped
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			state_r <= S_IDLE;
			opR <= `OP_READ;
			selR <= 2'h0;
			pollR <= 1'b0;
			stepR <= 3'h0;
			cycStart_r <= 1'b0;
			rdataR <= 16'h0000;
			prevR <= 16'h0000;
			pollPhase_r <= 1'b0;
			tmoSeen_r <= 1'b0;
			failR <= 1'b0;
			illegalR <= 1'b0;
		end else begin
			cycStart_r <= 1'b0;
			case (state_r)
				S_IDLE: begin
					if (startNow) begin
						opR <= newOp;
						selR <= hwdata[`CTRL_SEL_HI:`CTRL_SEL_LO];
						pollR <= hwdata[`CTRL_POLL];
						illegalR <= (newOp == `OP_BAD);
						if (newOp != `OP_BAD) begin
							failR <= 1'b0;
							stepR <= 3'h0;
							cycStart_r <= 1'b1;
							state_r <= S_SEQ;
						end
					end
				end
				S_SEQ: begin
					if (cycDone) begin
						if (stepRead)
							rdataR <= cycRdata;
						if (!stepLast) begin
							stepR <= stepR + 3'h1;
							cycStart_r <= 1'b1;
						end else if (pollR) begin
							pollPhase_r <= 1'b0;
							tmoSeen_r <= 1'b0;
							cycStart_r <= 1'b1;
							state_r <= S_POLL;
						end else begin
							state_r <= S_IDLE;
						end
					end
				end
				S_POLL: begin
					// reads come in pairs; a toggle bit that holds means done
					if (cycDone) begin
						rdataR <= cycRdata;
						prevR <= cycRdata;
						pollPhase_r <= ~pollPhase_r;
						if (!pollPhase_r) begin
							cycStart_r <= 1'b1;
						end else if (prevR[`BIT_TOGGLE] == cycRdata[`BIT_TOGGLE]) begin
							state_r <= S_IDLE;
						end else if (tmoSeen_r) begin
							failR <= 1'b1;
							cycStart_r <= 1'b1;
							state_r <= S_ABORT;
						end else begin
							tmoSeen_r <= cycRdata[`BIT_TIMEOUT];
							cycStart_r <= 1'b1;
						end
					end
				end
				S_ABORT: begin
					if (cycDone)
						state_r <= S_IDLE;
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // flash_host_ctrl

// ### rtl/sync_two_ff.v
// ==========================================
// two-stage synchroniser
module sync_two_ff #(
	parameter W = 1
) (
	input wire clk_sys, // system clock
	input wire rst_b, // async reset, low
	input wire [W-1:0] asyncIn, // pin level
	output reg [W-1:0] syncOut // synchronised level
);
	reg [W-1:0] meta_r;

	// meta_r is read by syncOut only
	always @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			meta_r <= {W{1'b0}};
			syncOut <= {W{1'b0}};
		end else begin
			meta_r <= asyncIn;
			syncOut <= meta_r;
		end
	end
endmodule // sync_two_ff

// ### sim/flash_command_decoder_bench.sv
module flash_command_decoder_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [31:0] rd;
	wire [31:0] hrdata;
	wire hreadyout, hresp, dqOe, ceN, weN, oeN, flashRstN, readyBusyN;
	wire [20:0] flashAddr;
	wire [15:0] dqIn, dqOut;
	int mismatches = 0;
	int checks = 0;
	int base;
	// op, write count, last address, last data
	logic [27:0] tbl [0:10] = '{28'h335_5588, 28'h445_5500, 28'h635_5520, 28'h725_555A,
		28'h825_5500, 28'h965_5510, 28'hA65_5530, 28'hB15_5530, 28'hC15_55B0,
		28'hD15_5530, 28'hE10_5598};
	initial forever #25 clk_sys = ~clk_sys;
	flash_host_ctrl dut_u (.clk_sys, .rst_b, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .flashAddr, .dqIn, .dqOut,
		.dqOe, .ceN, .weN, .oeN, .flashRstN, .readyBusyN);
	flash_dev_model dev_u (.flashAddr, .dqOut, .ceN, .weN, .oeN, .dqIn, .readyBusyN);
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic edgeRdy();
		for (int i = 0; i < 16; i++) begin
			@(posedge clk_sys);
			if (hreadyout === 1'b1) return;
		end
		mismatches++;
		tally_and_finish();
	endtask
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h00_0000, a};
		edgeRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		edgeRdy();
		rd = hrdata;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		ahb(1'b0, a, 32'h0000_0000);
		check(rd, exp);
	endtask
	// start an operation and poll status until it is no longer busy
	task automatic runOp(input logic [31:0] ctl);
		ahb(1'b1, 8'h00, ctl);
		for (int i = 0; i < 300; i++) begin
			ahb(1'b0, 8'h10, 32'h0000_0000);
			if (rd[0] === 1'b0) return;
		end
		mismatches++;
		tally_and_finish();
	endtask
	task automatic logChk(input int k, input logic [11:0] a, input logic [7:0] d);
		check({12'h000, dev_u.logA[base+k][11:0], dev_u.logD[base+k][7:0]}, {12'h000, a, d});
	endtask
	initial begin
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		@(posedge clk_sys);
		check(32'({ceN, weN, oeN, dqOe, hreadyout, hresp}), 32'h0000_003A);
		rdc(8'h14, 32'h0000_0002);
		rdc(8'h10, 32'h0000_0008);
		ahb(1'b1, 8'h20, 32'hFFFF_FFFF);
		rdc(8'h20, 32'h0000_0000);
		ahb(1'b1, 8'h04, 32'h0000_1234);
		ahb(1'b1, 8'h08, 32'h0000_A55A);
		base = dev_u.nLog;
		runOp(32'h0000_0045);
		check(32'(dev_u.nLog - base), 32'h0000_0004);
		logChk(0, 12'h555, 8'hAA);
		logChk(1, 12'h2AA, 8'h55);
		logChk(2, 12'h555, 8'hA0);
		check(32'(dev_u.logD[base+3]), 32'h0000_A55A);
		check(32'(dev_u.logA[base+3]), 32'h0000_1234);
		rdc(8'h10, 32'h0000_0008);
		runOp(32'h0000_0000);
		rdc(8'h0C, 32'h0000_A55A);
		check(32'(flashAddr), 32'h0000_1234);
		base = dev_u.nLog;
		runOp(32'h0000_0002);
		logChk(2, 12'h555, 8'h90);
		rdc(8'h0C, 32'h0000_005A);
		runOp(32'h0000_0022);
		rdc(8'h0C, 32'h0000_0080);
		runOp(32'h0000_0032);
		rdc(8'h0C, 32'h0000_0000);
		base = dev_u.nLog;
		runOp(32'h0000_0001);
		logChk(0, 12'h555, 8'hF0);
		runOp(32'h0000_0000);
		rdc(8'h0C, 32'h0000_A55A);
		ahb(1'b1, 8'h04, 32'h0000_0555);
		for (int i = 0; i < 11; i++) begin
			base = dev_u.nLog;
			runOp({28'h000_0000, tbl[i][27:24]});
			check(32'(dev_u.nLog - base), 32'(tbl[i][23:20]));
			logChk(int'(tbl[i][23:20]) - 1, tbl[i][19:8], tbl[i][7:0]);
			if (tbl[i][23:20] == 4'h6) logChk(2, 12'h555, 8'h80);
			if (tbl[i][27:24] == 4'hC) check(32'(dev_u.suspended), 32'h0000_0001);
		end
		check(32'(dev_u.nSect), 32'h0000_0002);
		check(32'(dev_u.suspended), 32'h0000_0000);
		ahb(1'b1, 8'h14, 32'h0000_0003);
		base = dev_u.nLog;
		runOp(32'h0000_000E);
		logChk(0, 12'h0AA, 8'h98);
		runOp(32'h0000_0003);
		logChk(1, 12'hAAA, 8'hAA);
		logChk(2, 12'h555, 8'h55);
		logChk(3, 12'hAAA, 8'h88);
		ahb(1'b1, 8'h14, 32'h0000_0001);
		@(posedge clk_sys);
		check(32'(flashRstN), 32'h0000_0000);
		ahb(1'b1, 8'h14, 32'h0000_0002);
		base = dev_u.nLog;
		runOp(32'h0000_000F);
		rdc(8'h10, 32'h0000_000C);
		check(32'(dev_u.nLog - base), 32'h0000_0000);
		// toggle with timeout never settles: fail flag and reset write
		base = dev_u.nLog;
		dev_u.stuck = 1'b1;
		runOp(32'h0000_0040);
		rdc(8'h10, 32'h0000_000A);
		check(32'(dev_u.nLog - base), 32'h0000_0001);
		logChk(0, 12'h555, 8'hF0);
		tally_and_finish();
	end
endmodule // flash_command_decoder_bench

// ### sim/flash_dev_model.sv
// ==========================================
// behavioural flash: logs every write, answers reads
module flash_dev_model #(
	parameter logic [15:0] MAKER = 16'h005A // arbitrary maker code
) (
	input wire logic [20:0] flashAddr, // address pins
	input wire logic [15:0] dqOut, // data from host
	input wire logic ceN, // chip select, low
	input wire logic weN, // write strobe, low
	input wire logic oeN, // output enable, low
	output logic [15:0] dqIn, // data to host
	output logic readyBusyN // pulled up while idle
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [20:0] logA [0:63];
	logic [15:0] logD [0:63];
	logic [15:0] mem [0:255];
	logic [20:0] latA;
	logic [15:0] pgm = 16'h0000;
	logic [15:0] val;
	logic [15:0] last = 16'h0000;
	logic idMode = 1'b0;
	logic tog = 1'b0;
	// bench sets this to model an operation that never finishes
	logic stuck = 1'b0;
	logic suspended = 1'b0;
	int nSect = 0;
	int nLog = 0;
	int busy = 0;
	wire wrSel = !weN && !ceN;
	wire rdSel = !oeN && !ceN;
	initial for (int i = 0; i < 256; i++) mem[i] = 16'h3C00 | 16'(i);
	always @(posedge wrSel) latA = flashAddr;
	always @(negedge wrSel) begin
		logA[nLog] = latA;
		logD[nLog] = dqOut;
		nLog++;
		// only the low byte carries commands
		if (dqOut[7:0] == 8'hF0) begin
			idMode = 1'b0;
			stuck = 1'b0;
		end
		else if (nLog > 2 && dqOut[7:0] == 8'h90 && logD[nLog-3][7:0] == 8'hAA) idMode = 1'b1;
		else if (nLog > 3 && logD[nLog-2][7:0] == 8'hA0 && logD[nLog-4][7:0] == 8'hAA) begin
			mem[latA[7:0]] = dqOut;
			pgm = dqOut;
			busy = 3;
		end else if (dqOut[7:0] == 8'hB0) begin
			if (nSect > 0) suspended = 1'b1;
		end else if (dqOut[7:0] == 8'h30) begin
			if (suspended) suspended = 1'b0;
			else if (nLog > 5 && logD[nLog-4][7:0] == 8'h80) nSect = 1;
			else if (nSect > 0) nSect++;
		end
	end
	always @(negedge rdSel) begin
		if (busy > 0 || stuck) tog = !tog;
		if (busy > 0) busy--;
	end
	always @* begin
		if (stuck) val = {8'h00, 1'b0, tog, 1'b1, 5'h00};
		else if (busy > 0) val = {8'h00, ~pgm[7], tog, 6'h00};
		else if (idMode) val = (flashAddr[7:0] == 8'h00) ? MAKER :
			(flashAddr[7:0] == 8'h03) ? 16'h0080 : 16'h0000;
		else val = mem[flashAddr[7:0]];
	end
	always @(val or rdSel) if (rdSel) last = val;
	// released bus shows the inverse, so a stale capture cannot pass
	assign dqIn = rdSel ? val : ~last;
	assign readyBusyN = (busy == 0);
endmodule // flash_dev_model

// ### sim/flash_host_ctrl_props.sv
// ==========================================
// pin and bus relations of the flash host controller
module flash_host_ctrl_props (
	input wire logic clk_sys, // system clock
	input wire logic rst_b, // async reset, low
	input wire logic hsel, // select
	input wire logic [31:0] haddr, // address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write
	input wire logic hready, // bus ready
	input wire logic [31:0] hwdata, // write data
	input wire logic [31:0] hrdata, // read data
	input wire logic hreadyout, // slave ready
	input wire logic hresp, // response
	input wire logic [20:0] flashAddr, // flash address
	input wire logic dqOe, // data driven
	input wire logic ceN, // chip select
	input wire logic weN, // write strobe
	input wire logic oeN, // output enable
	input wire logic flashRstN // flash reset
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence addrPh(logic w, logic [7:0] a);
		hsel && hready && htrans[1] && hwrite == w && haddr[7:0] == a;
	endsequence
	sequence wrPulse;
		$fell(weN) ##1 weN;
	endsequence
	a_bus_zero_wait: assert property (hreadyout && !hresp)
		else $error("slave stalled or answered an error");
	a_strobe_excl: assert property (!(!weN && !oeN))
		else $error("write and read strobes low together");
	a_strobe_in_ce: assert property ((!weN || !oeN) |-> !ceN)
		else $error("strobe low without chip select");
	a_wr_pulse: assert property ($fell(weN) |-> dqOe ##1 (weN && dqOe && $stable(flashAddr)))
		else $error("write pulse shape or address hold wrong");
	a_wr_release: assert property (wrPulse |=> !dqOe)
		else $error("data pins not released after write");
	a_rd_width: assert property ($fell(oeN) |-> !oeN [*4] ##1 oeN)
		else $error("read strobe width wrong");
	a_drive_only_wr: assert property ($rose(dqOe) |=> $fell(weN))
		else $error("data driven without a write pulse");
	a_cfg_reset_pin: assert property (addrPh(1, 8'h14) ##1 1 |=> flashRstN == $past(hwdata[1]))
		else $error("flash reset pin does not follow config");
	a_unmapped_zero: assert property (addrPh(0, 8'h20) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_cfg_upper_zero: assert property (addrPh(0, 8'h14) |=> hrdata[31:2] == 30'h0)
		else $error("config upper bits not zero");
endmodule // flash_host_ctrl_props

bind flash_host_ctrl flash_host_ctrl_props props_u (.clk_sys, .rst_b, .hsel, .haddr, .htrans,
	.hwrite, .hready, .hwdata, .hrdata, .hreadyout, .hresp, .flashAddr, .dqOe, .ceN, .weN,
	.oeN, .flashRstN);
